// >>> verilog/hsc_strap_port.sv
// Strap capture, port power enables, indicators and APB registers.
`timescale 1ns/1ps
module hsc_strap_port (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [hsc_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic serial_mode_strap,
	input wire logic serial_data_line,
	input wire logic serial_clock_line,
	input wire logic switch_polarity_strap,
	input wire logic spread_spectrum_strap,
	input wire logic full_power_mgmt_strap,
	input wire logic ganged_power_strap,
	input wire logic [3:0] port_power_enable_charge_strap_in,
	output logic [3:0] port_power_enable_charge_strap_out,
	output logic [3:0] port_power_enable_charge_strap_oe,
	input wire logic [3:0] port_overcurrent_n,
	input wire logic [3:0] port_power_req,
	input wire logic [11:0] port_state,
	input wire logic lp_local_request,
	input wire logic lp_remote_request,
	output logic lp_enter,
	output logic smbus_mode,
	output logic u1u2_disable,
	output logic u1u2_initiate_disable,
	output logic spread_spectrum_clocking,
	output logic power_switching,
	output logic individual_power,
	output logic [1:0] target_address,
	output logic [3:0] charge_enable,
	output logic [3:0] indicator_green,
	output logic [3:0] indicator_amber,
	output logic irq
);
	import hsc_pkg::*;

	// ----------------------------------------
	// Pin synchronisers.
	// ----------------------------------------
	logic [PIN_W-1:0] pin_raw;
	logic [PIN_W-1:0] pin_meta_reg;
	logic [PIN_W-1:0] pin_sync_reg;
	logic [3:0] oc_prev_reg;

	assign pin_raw = {port_overcurrent_n, port_power_enable_charge_strap_in, ganged_power_strap,
		full_power_mgmt_strap, spread_spectrum_strap, switch_polarity_strap,
		serial_clock_line, serial_data_line, serial_mode_strap};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta_reg <= PIN_RESET;
			pin_sync_reg <= PIN_RESET;
			oc_prev_reg <= 4'h0;
		end else begin
			pin_meta_reg <= pin_raw;
			pin_sync_reg <= pin_meta_reg;
			oc_prev_reg <= ~pin_sync_reg[PIN_OC +: NPORT];
		end
	end

	logic [3:0] oc_active;
	logic [3:0] oc_rise;
	assign oc_active = ~pin_sync_reg[PIN_OC +: NPORT];
	assign oc_rise = oc_active & ~oc_prev_reg;

	// ----------------------------------------
	// Strap capture sequence.
	// ----------------------------------------
	hsc_phase_t phase_reg;
	logic [1:0] settle_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_reg <= HSC_SETTLE;
			settle_reg <= 2'h0;
		end else begin
			unique case (phase_reg)
				HSC_SETTLE: begin
					settle_reg <= settle_reg + 2'h1;
					if (settle_reg == SETTLE_CYCLES - 2'h1) begin
						phase_reg <= HSC_CAPTURE;
					end
				end
				HSC_CAPTURE: begin
					phase_reg <= HSC_RUN;
				end
				HSC_RUN: begin
					phase_reg <= HSC_RUN;
				end
				default: begin
					phase_reg <= HSC_SETTLE;
				end
			endcase
		end
	end

	logic strap_smbus_reg;
	logic strap_lp_dis_reg;
	logic strap_lp_init_dis_reg;
	logic strap_pol_high_reg;
	logic strap_ssc_dis_reg;
	logic strap_fullpwr_n_reg;
	logic strap_ganged_reg;
	logic [3:0] strap_charge_reg;

	// Straps are taken once, on the capture cycle, and held until reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_smbus_reg <= 1'b0;
			strap_lp_dis_reg <= 1'b0;
			strap_lp_init_dis_reg <= 1'b0;
			strap_pol_high_reg <= 1'b0;
			strap_ssc_dis_reg <= 1'b0;
			strap_fullpwr_n_reg <= 1'b1;
			strap_ganged_reg <= 1'b1;
			strap_charge_reg <= 4'h0;
		end else if (phase_reg == HSC_CAPTURE) begin
			strap_smbus_reg <= ~pin_sync_reg[PIN_SERIAL_MODE];
			strap_lp_dis_reg <= pin_sync_reg[PIN_DATA];
			strap_lp_init_dis_reg <= pin_sync_reg[PIN_CLOCK];
			strap_pol_high_reg <= pin_sync_reg[PIN_POLARITY];
			strap_ssc_dis_reg <= pin_sync_reg[PIN_SSC];
			strap_fullpwr_n_reg <= pin_sync_reg[PIN_FULLPWR];
			strap_ganged_reg <= pin_sync_reg[PIN_GANGED];
			strap_charge_reg <= pin_sync_reg[PIN_CHARGE +: NPORT];
		end
	end

	// ----------------------------------------
	// APB register access.
	// ----------------------------------------
	logic [2:0] ctrl_reg;
	logic [3:0] status_reg;
	logic [3:0] mask_reg;
	logic access;
	logic done;
	logic mapped;
	logic [31:0] rdata_next;
	logic [3:0] power_on;

	assign access = psel && penable;
	assign done = access && pready;

	function automatic logic is_reg(input logic [11:0] a, input logic [11:0] off);
		return a == off;
	endfunction

	assign mapped = is_reg(paddr, OFF_CTRL) || is_reg(paddr, OFF_STRAP) ||
		is_reg(paddr, OFF_STATUS) || is_reg(paddr, OFF_MASK) || is_reg(paddr, OFF_PORT);

	always_comb begin
		rdata_next = 32'h0000_0000;
		if (is_reg(paddr, OFF_CTRL)) begin
			rdata_next[2:0] = ctrl_reg;
		end else if (is_reg(paddr, OFF_STRAP)) begin
			rdata_next[11:0] = {strap_charge_reg, strap_ganged_reg, strap_fullpwr_n_reg,
				strap_ssc_dis_reg, strap_pol_high_reg, strap_lp_init_dis_reg,
				strap_lp_dis_reg, strap_smbus_reg, phase_reg == HSC_RUN};
		end else if (is_reg(paddr, OFF_STATUS)) begin
			rdata_next[3:0] = status_reg;
		end else if (is_reg(paddr, OFF_MASK)) begin
			rdata_next[3:0] = mask_reg;
		end else if (is_reg(paddr, OFF_PORT)) begin
			rdata_next[7:0] = {oc_active, power_on};
		end
	end

	// One wait state: the answer is raised on the second access cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= access && !pready;
			pslverr <= access && !pready && !mapped;
			prdata <= (access && !pready && !pwrite) ? rdata_next : 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= CTRL_RESET;
			mask_reg <= 4'h0;
		end else if (done && pwrite) begin
			if (is_reg(paddr, OFF_CTRL)) begin
				ctrl_reg <= pwdata[2:0];
			end
			if (is_reg(paddr, OFF_MASK)) begin
				mask_reg <= pwdata[3:0];
			end
		end
	end

	// Over-current onset is sticky; a read clears only the bits it returned, a new event wins.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_reg <= 4'h0;
		end else if (done && !pwrite && is_reg(paddr, OFF_STATUS)) begin
			status_reg <= (status_reg & ~prdata[3:0]) | oc_rise;
		end else begin
			status_reg <= status_reg | oc_rise;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |((status_reg | oc_rise) & mask_reg);
		end
	end

	// ----------------------------------------
	// Effective configuration.
	// ----------------------------------------
	logic cfg_lp_dis;
	logic cfg_lp_init_dis;
	logic switching;
	assign cfg_lp_dis = ctrl_reg[CTRL_CFG_VALID] ? ctrl_reg[CTRL_LP_DIS] :
		strap_lp_dis_reg;
	assign cfg_lp_init_dis = ctrl_reg[CTRL_CFG_VALID] ? ctrl_reg[CTRL_LP_INIT_OVR] :
		strap_lp_init_dis_reg;
	assign switching = !strap_fullpwr_n_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			smbus_mode <= 1'b0;
			u1u2_disable <= 1'b0;
			u1u2_initiate_disable <= 1'b0;
			spread_spectrum_clocking <= 1'b1;
			power_switching <= 1'b0;
			individual_power <= 1'b0;
			target_address <= 2'h0;
			charge_enable <= 4'h0;
			lp_enter <= 1'b0;
		end else begin
			smbus_mode <= strap_smbus_reg;
			u1u2_disable <= cfg_lp_dis;
			u1u2_initiate_disable <= cfg_lp_init_dis;
			spread_spectrum_clocking <= !strap_ssc_dis_reg;
			power_switching <= switching;
			individual_power <= !strap_ganged_reg;
			target_address <= strap_smbus_reg ?
				{strap_ganged_reg, strap_fullpwr_n_reg} : 2'h0;
			charge_enable <= strap_charge_reg;
			lp_enter <= !cfg_lp_dis && (lp_remote_request ||
				(lp_local_request && !cfg_lp_init_dis));
		end
	end

	// ----------------------------------------
	// Port power enables and indicators.
	// ----------------------------------------
	logic [2:0] pstate [NPORT];

	always_comb begin
		for (int i = 0; i < NPORT; i++) begin
			pstate[i] = port_state[3*i +: 3];
		end
	end

	always_comb begin
		power_on = 4'h0;
		for (int i = 0; i < NPORT; i++) begin
			if (!switching) begin
				power_on[i] = 1'b1;
			end else if (strap_ganged_reg) begin
				power_on[i] = (|port_power_req) && !(|oc_active);
			end else begin
				power_on[i] = port_power_req[i] && !oc_active[i];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_power_enable_charge_strap_out <= 4'h0;
			port_power_enable_charge_strap_oe <= 4'h0;
		end else if (phase_reg == HSC_RUN) begin
			port_power_enable_charge_strap_oe <= 4'hF;
			port_power_enable_charge_strap_out <= strap_pol_high_reg ?
				power_on : ~power_on;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			indicator_green <= 4'h0;
			indicator_amber <= 4'h0;
		end else begin
			for (int i = 0; i < NPORT; i++) begin
				indicator_green[i] <= pstate[i] == PS_ENABLED;
				indicator_amber[i] <= oc_active[i] &&
					((switching && pstate[i] == PS_POWERED_OFF) ||
					(!switching && pstate[i] == PS_DISCONNECTED));
			end
		end
	end

endmodule

// >>> include/hsc_pkg.sv
// Constants for the strap loader and downstream port power block.
// What this block does
// - Serial mode: I2C default, SMBus when strap low.
// - Data line high at reset disables U1/U2.
// - Configuration bit overrides data-line strap when supplied.
// - Clock line high disables U1/U2 initiation.
// - Remote U1/U2 requests accepted; own initiation suppressed.
// - Configuration bit overrides clock-line strap when supplied.
// - Polarity strap high makes switch enables active high.
// - Spread spectrum on unless strap high.
// - Power-management strap low enables port power control.
// - Ganged strap low selects individual port power.
// - Power straps double as SMBus target address.
// - Per-port charge strap high enables battery charging.
// - Charge strap pins become power enable outputs.
// - Indicator green when active, amber on over-current while powered off (switching) or disconnected (no switching).
package hsc_pkg;

	localparam int NPORT = 4;
	localparam int ADDR_W = 12;

	// ----------------------------------------
	// Register offsets.
	// ----------------------------------------
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_STRAP = 12'h004;
	localparam logic [11:0] OFF_STATUS = 12'h008;
	localparam logic [11:0] OFF_MASK = 12'h00C;
	localparam logic [11:0] OFF_PORT = 12'h010;

	// ----------------------------------------
	// Field positions.
	// ----------------------------------------
	localparam int CTRL_CFG_VALID = 0;
	localparam int CTRL_LP_DIS = 1;
	localparam int CTRL_LP_INIT_OVR = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;

	// Synchronised pin vector layout.
	localparam int PIN_SERIAL_MODE = 0;
	localparam int PIN_DATA = 1;
	localparam int PIN_CLOCK = 2;
	localparam int PIN_POLARITY = 3;
	localparam int PIN_SSC = 4;
	localparam int PIN_FULLPWR = 5;
	localparam int PIN_GANGED = 6;
	localparam int PIN_CHARGE = 7;
	localparam int PIN_OC = 11;
	localparam int PIN_W = 15;
	localparam logic [14:0] PIN_RESET = 15'h7800;

	// ----------------------------------------
	// Timing counts.
	// ----------------------------------------
	localparam int SYNC_DEPTH = 2;
	localparam logic [1:0] SETTLE_CYCLES = 2'h2;

	// ----------------------------------------
	// Downstream port states as reported by the hub core.
	// ----------------------------------------
	localparam logic [2:0] PS_POWERED_OFF = 3'h0;
	localparam logic [2:0] PS_DISCONNECTED = 3'h1;
	localparam logic [2:0] PS_ENABLED = 3'h2;
	localparam logic [2:0] PS_SUSPENDED = 3'h3;

	typedef enum logic [1:0] {
		HSC_SETTLE = 2'b00,
		HSC_CAPTURE = 2'b01,
		HSC_RUN = 2'b10
	} hsc_phase_t;

endpackage

// >>> dv/hsc_switch_model.sv
// Model of the downstream power switches and over-current detectors.
`timescale 1ns/1ps
module hsc_switch_model (
	input wire logic [3:0] drive,
	input wire logic [3:0] drive_oe,
	input wire logic [3:0] strap_level,
	input wire logic [3:0] trip,
	output logic [3:0] pin_level,
	output logic [3:0] overcurrent_n
);
	// The strap resistor sets the pin while the device leaves it undriven.
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pin_level[i] = drive_oe[i] ? drive[i] : strap_level[i];
		end
	end
	// A fault pulls the line low; the pull-up holds it high otherwise.
	assign overcurrent_n = ~trip;
endmodule

// >>> dv/hsc_strap_port_sva.sv
// Checker for the strap loader and port power block.
`timescale 1ns/1ps
module hsc_strap_port_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [3:0] port_power_enable_charge_strap_oe,
	input wire logic [11:0] port_state,
	input wire logic lp_local_request,
	input wire logic lp_remote_request,
	input wire logic lp_enter,
	input wire logic smbus_mode,
	input wire logic u1u2_disable,
	input wire logic u1u2_initiate_disable,
	input wire logic [1:0] target_address,
	input wire logic [3:0] charge_enable,
	input wire logic [3:0] indicator_green
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_wait: assert property (psel && penable && !pready |=> pready) else $error("no ready");
	a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
	a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000) else $error("stray data");
	a_oe_stays: assert property (port_power_enable_charge_strap_oe[0] |=>
		port_power_enable_charge_strap_oe == 4'hf) else $error("enable pins dropped");
	a_straps_held: assert property (port_power_enable_charge_strap_oe[0] &&
		$past(port_power_enable_charge_strap_oe[0]) |-> $stable(charge_enable) &&
		$stable(smbus_mode)) else $error("strap changed");
	a_addr_i2c: assert property (!smbus_mode |-> target_address == 2'b00) else $error("addr");
	a_lp_blocked: assert property (u1u2_disable ##1 u1u2_disable |-> !lp_enter)
		else $error("entry while disabled");
	a_remote_taken: assert property (!u1u2_disable && lp_remote_request ##1 !u1u2_disable
		|-> lp_enter) else $error("remote refused");
	a_local_held: assert property (u1u2_initiate_disable && !lp_remote_request ##1
		u1u2_initiate_disable |-> !lp_enter) else $error("own entry");
	a_green_on: assert property (port_state[2:0] == hsc_pkg::PS_ENABLED |=> indicator_green[0])
		else $error("no green");
	c_err: cover property (pslverr);
	c_lp: cover property (lp_enter);
	c_green: cover property (indicator_green[0]);
endmodule
bind hsc_strap_port hsc_strap_port_sva chk_u (.pclk, .presetn, .psel, .penable, .prdata,
	.pready, .pslverr, .port_power_enable_charge_strap_oe, .port_state, .lp_local_request,
	.lp_remote_request, .lp_enter, .smbus_mode, .u1u2_disable, .u1u2_initiate_disable,
	.target_address, .charge_enable, .indicator_green);

// >>> dv/hub_strap_config_port_power_tb.sv
// Self-checking bench for the strap loader and port power block.
`timescale 1ns/1ps
module hub_strap_config_port_power_tb;
	import hsc_pkg::*;
	typedef struct packed {
		logic [6:0] strap;
		logic [3:0] charge;
		logic [7:0] mode;
		logic [3:0] pin;
	} hsc_row_t;
	hsc_row_t rows [4] = '{{7'h61, 4'h0, 8'h10, 4'h0}, {7'h1e, 4'ha, 8'hec, 4'h0},
		{7'h44, 4'h5, 8'hba, 4'hf}, {7'h3a, 4'h3, 8'hc5, 4'hf}};
	logic [5:0] lpv [4] = '{6'h0d, 6'h2c, 6'h2b, 6'h1a};
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [6:0] straps = 7'h61;
	logic [3:0] charge = 4'h0;
	logic [3:0] trip = 4'h0;
	logic [3:0] preq = 4'h0;
	logic [11:0] pstate = 12'h000;
	logic lp_loc = 1'b0;
	logic lp_rem = 1'b0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, lp_enter, irq, er;
	wire [7:0] mode_o;
	logic [3:0] chg_o, green, amber, pin, pin_out, pin_oe, oc_n;
	int n_mismatch = 0;
	int cmp_count = 0;
	initial forever #2.5 pclk = ~pclk;
	hsc_strap_port dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .serial_mode_strap(straps[0]), .serial_data_line(straps[1]),
		.serial_clock_line(straps[2]), .switch_polarity_strap(straps[3]),
		.spread_spectrum_strap(straps[4]), .full_power_mgmt_strap(straps[5]),
		.ganged_power_strap(straps[6]), .port_power_enable_charge_strap_in(pin),
		.port_power_enable_charge_strap_out(pin_out), .port_power_enable_charge_strap_oe(pin_oe),
		.port_overcurrent_n(oc_n), .port_power_req(preq), .port_state(pstate),
		.lp_local_request(lp_loc), .lp_remote_request(lp_rem), .lp_enter,
		.smbus_mode(mode_o[7]), .u1u2_disable(mode_o[6]), .u1u2_initiate_disable(mode_o[5]),
		.spread_spectrum_clocking(mode_o[4]), .power_switching(mode_o[3]),
		.individual_power(mode_o[2]), .target_address(mode_o[1:0]), .charge_enable(chg_o),
		.indicator_green(green), .indicator_amber(amber), .irq);
	hsc_switch_model sw_u (.drive(pin_out), .drive_oe(pin_oe), .strap_level(charge), .trip,
		.pin_level(pin), .overcurrent_n(oc_n));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			n_mismatch++;
			close_out();
		end
		@(posedge pclk);
	endtask
	task automatic rst(input hsc_row_t r);
		presetn <= 1'b0;
		straps <= r.strap;
		charge <= r.charge;
		repeat (4) @(posedge pclk);
		chk(32'(mode_o[4]), 32'h0000_0001);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
	endtask
	// ----------------------------------------
	// Main sequence.
	// ----------------------------------------
	initial begin
		@(posedge pclk);
		foreach (rows[i]) begin
			rst(rows[i]);
			chk(32'(mode_o), 32'(rows[i].mode));
			chk(32'(chg_o), 32'(rows[i].charge));
			chk(32'(pin), 32'(rows[i].pin));
			straps <= ~rows[i].strap;
			charge <= ~rows[i].charge;
			repeat (4) @(posedge pclk);
			chk(32'({mode_o, chg_o}), 32'({rows[i].mode, rows[i].charge}));
		end
		rst(rows[1]);
		apb(1'b0, OFF_STRAP, 32'h0000_0000);
		chk(rd, 32'h0000_0a3f);
		foreach (lpv[i]) begin
			apb(1'b1, OFF_CTRL, 32'(lpv[i][5:3]));
			lp_loc <= lpv[i][2];
			lp_rem <= lpv[i][1];
			repeat (2) @(posedge pclk);
			chk(32'(lp_enter), 32'(lpv[i][0]));
			chk(32'(mode_o[6:5]), 32'({lpv[i][4], lpv[i][5]}));
			lp_loc <= 1'b0;
			lp_rem <= 1'b0;
			@(posedge pclk);
		end
		apb(1'b0, 12'h020, 32'h0000_0000);
		chk(32'(er), 32'h0000_0001);
		apb(1'b1, OFF_MASK, 32'h0000_0001);
		preq <= 4'h3;
		repeat (4) @(posedge pclk);
		chk(32'(pin), 32'h0000_0003);
		trip <= 4'h1;
		repeat (6) @(posedge pclk);
		chk(32'({irq, amber, pin}), 32'h0000_0112);
		apb(1'b0, OFF_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0001);
		repeat (2) @(posedge pclk);
		chk(32'(irq), 32'h0000_0000);
		pstate <= 12'h010;
		repeat (3) @(posedge pclk);
		chk(32'(green), 32'h0000_0002);
		close_out();
	end
endmodule
